// >>> core/vad_decision.sv
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps

// What this block does
// R1 - Tone when 4th order error below 0,0447
// R2 - Pole below 385 Hz means noise
// R3 - Tone test uses reflection coefficients one to four
// R4 - Low input energy loads threshold floor
// R5 - Adapt only steady, aperiodic, toneless frames
// R6 - Reduce threshold by 1/32, keep if high
// R7 - Otherwise raise by 1/16, capped by target
// R8 - Threshold never above energy plus headroom
// R9 - Reset threshold, predictor vector, adaptation counter
// R10 - Raw decision when energy exceeds threshold
// R11 - Three burst frames load hang counter five
// R12 - Decision ORs hangover, hang counter counts down
// R13 - Count lag pairs that are near multiples
// R14 - Periodic when two frame counts reach seven
// R15 - Previous last lag feeds next frame
// R16 - Periodicity updates after decision, used next frame
// R17 - Decision starts once inputs are valid
// R18 - Reset returns all decision state to initial
// R19 - Energies held as exponent and normalised mantissa
// R20 - Compare exponents first, then mantissas
// R21 - Constants held in exponent and mantissa form
// R22 - Filtered energy from predictor vector and input
// R23 - Steady when distortion change below 0,068
// R24 - Frame strobe updates decision, post strobe periodicity
module vad_decision (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                frame_stb,
	input  wire vad_pkg::frame_in_s  frame_in,
	input  wire vad_pkg::rvad_t      avg_pred_autocorr,
	input  wire logic                post_stb,
	input  wire vad_pkg::lags_t      lags,
	output logic                     vad_flag,
	output logic                     raw_vad,
	output logic                     tone_flag,
	output logic                     periodic_flag,
	output logic                     frame_done
);

	vad_pkg::vad_state_s st_r;      // Registered state.
	vad_pkg::vad_state_s st_nxt;    // Next state.
	logic                tone_now;  // Tone verdict of the presented frame.
	logic [16:0]         perr;      // Normalised prediction error, Q15.
	logic                steady_now; // Spectrum steadiness of the presented frame.
	logic [63:0]         pvad_mag;  // Filtered energy as integer.
	logic [31:0]         acf0_mag;  // Input energy as integer.
	vad_pkg::fp_s        pvad_fp;   // Filtered energy, pseudo-float.
	vad_pkg::fp_s        acf0_fp;   // Input energy, pseudo-float.
	vad_pkg::fp_s        dec_fp;    // Threshold after the decrease step.
	vad_pkg::fp_s        inc_fp;    // Decreased threshold after the increase step.
	vad_pkg::fp_s        fac_fp;    // Filtered energy times the steady factor.
	vad_pkg::fp_s        lim_fp;    // Filtered energy plus headroom.
	vad_pkg::fp_s        big_fp;    // Larger addend of the headroom sum.
	vad_pkg::fp_s        small_fp;  // Smaller addend of the headroom sum.
	logic [16:0]         sum_m;     // Aligned mantissa sum.
	vad_pkg::fp_s        thv_adapt; // Threshold after the adaptation steps.
	vad_pkg::fp_s        thv_new;   // Adapted threshold after clamping.
	logic [2:0]          lagcount;  // Lag matches of the presented frame.
	logic                low_energy; // Input energy below the low limit.
	logic                adapt_now; // Adaptation conditions all hold.
	logic                soft_rst;  // Software reset, one access edge.
	logic [21:0]         dec_prod;
	logic [21:0]         inc_prod;
	logic [27:0]         fac_prod;

	// Tone detection: the pole test guards against low resonances before the
	// prediction gain is believed.
	always_comb begin
		logic signed [31:0] sq;
		logic [16:0]        om;
		logic [33:0]        prod;
		logic signed [17:0] a1;
		logic signed [35:0] a1sq;
		logic signed [39:0] im;
		logic signed [63:0] lhs;
		logic signed [63:0] rhs;
		logic               pole_noise;
		sq = '0;
		om = '0;
		prod = '0;
		a1 = '0;
		a1sq = '0;
		im = '0;
		lhs = '0;
		rhs = '0;
		pole_noise = 1'b0;
		perr = vad_pkg::Q15_ONE;
		// The error shrinks by (1 - k*k) per lattice stage. [R3]
		for (int i = 0; i < 4; i++) begin
			sq = $signed(frame_in.reflection_coefs[i]) * $signed(frame_in.reflection_coefs[i]);
			om = vad_pkg::Q15_ONE - 17'(sq >>> 15);
			prod = perr * om;
			perr = prod[31:15];
		end
		// Second order direct form coefficients from the first two stages. [R3]
		// The cross product is held at full width first; sizing it inside the cast
		// would drop its upper bits before the scaling back to Q15.
		sq = $signed(frame_in.reflection_coefs[0]) * $signed(frame_in.reflection_coefs[1]);
		a1 = 18'($signed(frame_in.reflection_coefs[0])) + 18'(sq >>> 15);
		a1sq = a1 * a1;
		im = (40'($signed(frame_in.reflection_coefs[1])) <<< 17) - 40'(a1sq);
		lhs = 64'(im) <<< 15;
		rhs = $signed({48'h0000_0000_0000, vad_pkg::FREQTH}) * 64'(a1sq);
		// Real poles, or complex right-half poles below the limit, are noise. [R2]
		pole_noise = (im < 0) || ((a1 <= 0) && (lhs < rhs));
		tone_now = !pole_noise && (perr < vad_pkg::PREDTH); // [R1]
	end

	// Filtered energy from the stored predictor vector and this frame's input,
	// and the steadiness of the spectrum.
	always_comb begin
		logic signed [63:0] acc;
		logic [32:0]        diff;
		acc = '0;
		diff = '0;
		for (int i = 0; i < 9; i++) begin
			if (i == 0) begin
				acc = acc + 64'($signed(st_r.rvad[i]) * $signed(frame_in.acf[i])); // [R22]
			end else begin
				acc = acc + (64'($signed(st_r.rvad[i]) * $signed(frame_in.acf[i])) <<< 1);
			end
		end
		// Rounding can make a tiny energy negative; it is treated as zero.
		pvad_mag = acc[63] ? 64'h0000_0000_0000_0000 : acc;
		acf0_mag = frame_in.acf[0][31] ? 32'h0000_0000 : frame_in.acf[0];
		diff = 33'($signed(frame_in.dm)) - 33'($signed(st_r.lastdm));
		if (diff[32]) begin
			diff = -diff;
		end
		steady_now = diff < vad_pkg::STAT_THRESH; // [R23]
	end

	// Threshold arithmetic in pseudo-float. [R19]
	assign dec_prod = st_r.thvad.m * vad_pkg::DEC_MUL;
	assign inc_prod = dec_fp.m * vad_pkg::INC_MUL;
	assign fac_prod = pvad_fp.m * vad_pkg::FAC_MUL;

	fp_normalize #(.W(64)) u_norm_pvad (.val(pvad_mag), .exp_base(16'sh000F), .res(pvad_fp));
	fp_normalize #(.W(32)) u_norm_acf0 (.val(acf0_mag), .exp_base(16'sh000F), .res(acf0_fp));
	fp_normalize #(.W(22)) u_norm_dec (
		.val(dec_prod), .exp_base(st_r.thvad.e - vad_pkg::DEC_SHIFT), .res(dec_fp));
	fp_normalize #(.W(22)) u_norm_inc (
		.val(inc_prod), .exp_base(dec_fp.e - vad_pkg::INC_SHIFT), .res(inc_fp));
	fp_normalize #(.W(28)) u_norm_fac (
		.val(fac_prod), .exp_base(pvad_fp.e - vad_pkg::FAC_SHIFT), .res(fac_fp));
	fp_normalize #(.W(17)) u_norm_lim (.val(sum_m), .exp_base(big_fp.e), .res(lim_fp));

	// Headroom sum: the smaller addend is aligned to the larger exponent.
	always_comb begin
		int d;
		d = 0;
		if (vad_pkg::fp_lt(pvad_fp, vad_pkg::FP_MARGIN)) begin
			big_fp = vad_pkg::FP_MARGIN;
			small_fp = pvad_fp;
		end else begin
			big_fp = pvad_fp;
			small_fp = vad_pkg::FP_MARGIN;
		end
		d = int'(big_fp.e) - int'(small_fp.e);
		// Beyond 16 places the smaller addend contributes nothing.
		if (d >= 16) begin
			sum_m = {1'b0, big_fp.m};
		end else begin
			sum_m = {1'b0, big_fp.m} + {1'b0, small_fp.m >> d};
		end
	end

	// Adaptation steps and clamp.
	always_comb begin
		if (!vad_pkg::fp_lt(dec_fp, fac_fp)) begin
			thv_adapt = dec_fp; // [R6]
		end else if (vad_pkg::fp_lt(inc_fp, fac_fp)) begin
			thv_adapt = inc_fp; // [R7]
		end else begin
			thv_adapt = fac_fp; // [R7]
		end
		thv_new = vad_pkg::fp_lt(lim_fp, thv_adapt) ? lim_fp : thv_adapt; // [R8]
	end

	assign low_energy = vad_pkg::fp_lt(acf0_fp, vad_pkg::FP_PTH); // [R20] [R21]
	assign adapt_now = steady_now && !st_r.periodic && !tone_now; // [R5]

	// Lag comparison; the difference may go negative and then counts as a match.
	always_comb begin
		logic [7:0]        lv [5];
		logic [7:0]        smallag;
		logic [7:0]        mn;
		logic signed [9:0] rem;
		lv[0] = st_r.lag0; // [R15]
		for (int j = 1; j < 5; j++) begin
			lv[j] = lags[j-1];
		end
		lagcount = 3'h0;
		smallag = '0;
		mn = '0;
		rem = '0;
		for (int j = 1; j < 5; j++) begin
			smallag = (lv[j] > lv[j-1]) ? lv[j] : lv[j-1];
			for (int i = 1; i < 4; i++) begin
				mn = (lv[i] < lv[i-1]) ? lv[i] : lv[i-1];
				if (smallag >= mn) begin
					smallag = smallag - mn; // [R13]
				end
			end
			mn = (lv[j] < lv[j-1]) ? lv[j] : lv[j-1];
			rem = $signed({2'b00, mn}) - $signed({2'b00, smallag});
			if ({1'b0, smallag} < vad_pkg::LTHRESH || rem < $signed({1'b0, vad_pkg::LTHRESH})) begin
				lagcount = lagcount + 3'h1; // [R13]
			end
		end
	end

	assign soft_rst = psel && penable && pwrite && (paddr == vad_pkg::OFS_CTRL)
		&& pwdata[vad_pkg::CTRL_SOFT_RST_BIT];

	// Next state: register access, frame decision, post-frame periodicity.
	always_comb begin
		logic [2:0]          burst_n;
		logic signed [3:0]   hang_n;
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		burst_n = '0;
		hang_n = '0;
		// Read data and error are prepared in the setup cycle.
		if (psel && !penable) begin
			st_nxt.pslverr = 1'b0;
			case (paddr)
				vad_pkg::OFS_CTRL: begin
					st_nxt.prdata = 32'h0000_0000;
				end
				vad_pkg::OFS_STATUS: begin
					st_nxt.prdata = {8'h00, st_r.adapt_cnt, st_r.hang, 2'b00, st_r.burst,
						3'b000, st_r.steady, st_r.periodic, st_r.tone, st_r.raw, st_r.vad};
				end
				vad_pkg::OFS_THVAD: begin
					st_nxt.prdata = st_r.thvad;
				end
				vad_pkg::OFS_PVAD: begin
					st_nxt.prdata = st_r.pvad;
				end
				default: begin
					// Unmapped or misaligned offsets answer zero with an error.
					st_nxt.prdata = 32'h0000_0000;
					st_nxt.pslverr = 1'b1;
				end
			endcase
		end
		// Inputs are taken on the strobe, when the encoder holds them valid. [R17] [R24]
		if (frame_stb) begin
			st_nxt.steady = steady_now;
			st_nxt.lastdm = frame_in.dm;
			st_nxt.tone = tone_now;
			st_nxt.pvad = pvad_fp;
			if (low_energy) begin
				st_nxt.thvad = vad_pkg::FP_PLEV; // [R4]
			end else if (adapt_now) begin
				st_nxt.thvad = thv_new; // [R5]
				st_nxt.rvad = avg_pred_autocorr; // [R5]
				if (st_r.adapt_cnt != vad_pkg::ADAPT_MAX) begin
					st_nxt.adapt_cnt = st_r.adapt_cnt + 8'h01;
				end
			end
			st_nxt.raw = vad_pkg::fp_lt(st_nxt.thvad, pvad_fp); // [R10] [R20]
			burst_n = st_nxt.raw ? {1'b0, st_r.burst} + 3'h1 : 3'h0; // [R11]
			hang_n = st_r.hang;
			if (burst_n >= vad_pkg::BURST_CONST) begin
				hang_n = vad_pkg::HANG_CONST; // [R11]
				burst_n = vad_pkg::BURST_CONST;
			end
			st_nxt.vad = st_nxt.raw || (hang_n >= 0); // [R12]
			if (hang_n >= 0) begin
				hang_n = hang_n - 4'sh1; // [R12]
			end
			st_nxt.burst = burst_n[1:0];
			st_nxt.hang = hang_n;
			st_nxt.done = 1'b1;
		end
		// Periodicity is refreshed only here, so a frame sees the last one. [R16]
		if (post_stb) begin
			st_nxt.vold_cnt = st_r.old_cnt; // [R14]
			st_nxt.old_cnt = lagcount;
			st_nxt.periodic = ({1'b0, lagcount} + {1'b0, st_r.old_cnt}) >= vad_pkg::NTHRESH;
			st_nxt.lag0 = lags[3]; // [R15]
		end
		// Software reset restores every algorithm variable. [R18]
		if (soft_rst) begin
			st_nxt = vad_pkg::VAD_RESET;
		end
	end

	// Single state register. [R9] [R18]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= vad_pkg::VAD_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// The slave answers in the first access cycle.
	assign pready = psel && penable;
	assign prdata = st_r.prdata;
	assign pslverr = st_r.pslverr && psel && penable;
	assign vad_flag = st_r.vad;
	assign raw_vad = st_r.raw;
	assign tone_flag = st_r.tone;
	assign periodic_flag = st_r.periodic;
	assign frame_done = st_r.done;

	// Checks.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic signed [3:0]   hang_q;
	vad_pkg::rvad_t      rvad_q;
	logic [7:0]          lag4_q;
	assign hang_q = st_r.hang;
	assign rvad_q = st_r.rvad;
	assign lag4_q = lags[3];

	sequence s_third_burst;
		frame_stb && !soft_rst && st_r.burst == 2'h2 && vad_pkg::fp_lt(st_nxt.thvad, pvad_fp);
	endsequence

	AST_HANG_LOAD: assert property (s_third_burst |=> st_r.hang == 4'sh4 && st_r.burst == 2'h3) // [R11]
		else $error("hang counter not loaded after third burst frame");
	AST_HANG_FLAG: assert property (frame_stb && !soft_rst |=>
		vad_flag == (raw_vad || st_r.hang != 4'shF || $past(hang_q) >= 0)) // [R12]
		else $error("hangover decision wrong");
	AST_RAW: assert property (frame_done |-> raw_vad == vad_pkg::fp_lt(st_r.thvad, st_r.pvad)) // [R10]
		else $error("raw decision disagrees with energy and threshold");
	AST_LOW_ENERGY: assert property (frame_stb && !soft_rst && low_energy |=>
		st_r.thvad == vad_pkg::FP_PLEV && $stable(rvad_q)) // [R4]
		else $error("low energy frame did not load floor");
	AST_NO_ADAPT: assert property (frame_stb && !soft_rst && (st_r.periodic || tone_now) |=>
		$stable(rvad_q)) // [R5]
		else $error("predictor vector adapted while blocked");
	AST_CLAMP: assert property (frame_stb && !soft_rst && !low_energy && adapt_now |=>
		!vad_pkg::fp_lt($past(lim_fp), st_r.thvad)) // [R8]
		else $error("threshold above energy plus headroom");
	AST_HISTORY: assert property (post_stb && !soft_rst |=> st_r.vold_cnt == $past(st_r.old_cnt)
		&& periodic_flag == ({1'b0, st_r.old_cnt} + {1'b0, st_r.vold_cnt} >= vad_pkg::NTHRESH)) // [R14]
		else $error("periodicity history wrong");
	AST_LAG0: assert property (post_stb && !soft_rst |=> st_r.lag0 == $past(lag4_q)) // [R15]
		else $error("last lag not carried over");
	AST_PER_HOLD: assert property (!post_stb && !soft_rst |=> $stable(periodic_flag)) // [R16]
		else $error("periodic flag changed without post strobe");
	AST_TONE: assert property (frame_stb && !soft_rst |=> tone_flag == $past(tone_now)
		&& (!tone_flag || $past(perr) < vad_pkg::PREDTH)) // [R1]
		else $error("tone set with high prediction error");
	AST_NORM: assert property (st_r.thvad.m >= vad_pkg::MANT_MIN) // [R19]
		else $error("threshold mantissa not normalised");

endmodule

// >>> pkg/vad_pkg.sv
package vad_pkg;

	// Pseudo-floating value: 2**e * m / 32768, with m kept at or above 16384 except in the zero code.
	typedef struct packed {
		logic signed [15:0] e;
		logic [15:0]        m;
	} fp_s;

	// Autocorrelation vector of the adaptive filter predictor, element 0 first.
	typedef logic [8:0][15:0] rvad_t;

	// Four long term predictor lags of one frame; index 0 is the first sub-frame.
	typedef logic [3:0][7:0] lags_t;

	// Per-frame analysis values handed over by the encoder.
	typedef struct packed {
		logic [8:0][31:0] acf;
		logic [3:0][15:0] reflection_coefs;
		logic [31:0]      dm;
	} frame_in_s;

	// Complete state of the decision block.
	typedef struct packed {
		fp_s         thvad;
		fp_s         pvad;
		rvad_t       rvad;
		logic [7:0]  adapt_cnt;
		logic [31:0] lastdm;
		logic        steady;
		logic        tone;
		logic        raw;
		logic        vad;
		logic [1:0]  burst;
		logic signed [3:0] hang;
		logic [7:0]  lag0;
		logic [2:0]  old_cnt;
		logic [2:0]  vold_cnt;
		logic        periodic;
		logic        done;
		logic [31:0] prdata;
		logic        pslverr;
	} vad_state_s;

	// Zero has the most negative exponent so that it orders below every value.
	localparam logic signed [15:0] FP_ZERO_EXP = 16'sh8000;
	localparam fp_s FP_ZERO   = '{e: FP_ZERO_EXP, m: 16'h0000};
	localparam logic [15:0] MANT_MIN = 16'h4000;
	localparam fp_s FP_PTH    = '{e: 16'sh0012, m: 16'h668A};
	localparam fp_s FP_MARGIN = '{e: 16'sh001B, m: 16'h6ACF};
	localparam fp_s FP_PLEV   = '{e: 16'sh0014, m: 16'h445C};
	localparam fp_s FP_THV_INIT = '{e: 16'sh0015, m: 16'h5573};

	// Threshold step factors as multiplier and right shift.
	localparam logic [5:0]  DEC_MUL   = 6'h1F;
	localparam logic signed [15:0] DEC_SHIFT = 16'sh0005;
	localparam logic [5:0]  INC_MUL   = 6'h11;
	localparam logic signed [15:0] INC_SHIFT = 16'sh0004;
	// Steady state factor 2,55 held as 2611/1024.
	localparam logic [11:0] FAC_MUL   = 12'hA33;
	localparam logic signed [15:0] FAC_SHIFT = 16'sh000A;

	// Q15 constants of the tone and steadiness tests.
	localparam logic [16:0] Q15_ONE     = 17'h0_8000;
	localparam logic [16:0] PREDTH      = 17'h0_05B9;
	localparam logic [15:0] FREQTH      = 16'h0C74;
	localparam logic [32:0] STAT_THRESH = 33'h0_0000_08B4;

	localparam logic [2:0]  BURST_CONST = 3'h3;
	localparam logic signed [3:0] HANG_CONST = 4'sh5;
	localparam logic signed [3:0] HANG_INIT  = 4'shF;
	localparam logic [8:0]  LTHRESH     = 9'h002;
	localparam logic [3:0]  NTHRESH     = 4'h7;
	localparam logic [7:0]  LAG0_INIT   = 8'h15;
	localparam logic [15:0] RVAD0_INIT  = 16'h0006;
	localparam logic [7:0]  ADAPT_MAX   = 8'hFF;

	// Register offsets and fields.
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_THVAD  = 8'h08;
	localparam logic [7:0] OFS_PVAD   = 8'h0C;
	localparam int CTRL_SOFT_RST_BIT = 0;

	localparam vad_state_s VAD_RESET = '{
		thvad: FP_THV_INIT, pvad: FP_ZERO,
		rvad: {128'h0000_0000_0000_0000_0000_0000_0000_0000, RVAD0_INIT},
		adapt_cnt: 8'h00, lastdm: 32'h0000_0000, steady: 1'b0, tone: 1'b0,
		raw: 1'b0, vad: 1'b0, burst: 2'h0, hang: HANG_INIT, lag0: LAG0_INIT,
		old_cnt: 3'h0, vold_cnt: 3'h0, periodic: 1'b1, done: 1'b0,
		prdata: 32'h0000_0000, pslverr: 1'b0};

	// Ordering of two pseudo-floating values: exponent first, then mantissa.
	function automatic logic fp_lt(input fp_s a, input fp_s b);
		if (a.e != b.e) begin
			return a.e < b.e;
		end
		return a.m < b.m;
	endfunction

endpackage

// >>> core/fp_normalize.sv
`timescale 1ns/1ps

// Turns an unsigned value times 2**(exp_base-15) into a normalised pseudo-float.
module fp_normalize #(
	parameter int W = 32
) (
	input  wire logic [W-1:0]      val,
	input  wire logic signed [15:0] exp_base,
	output vad_pkg::fp_s           res
);

	// A priority search finds the leading one; the shift then puts it on bit 14.
	always_comb begin
		int q;
		logic [W+14:0] sh;
		q = -1;
		sh = '0;
		for (int i = 0; i < W; i++) begin
			if (val[i]) begin
				q = i;
			end
		end
		if (q < 0) begin
			// An all-zero input has no leading one and maps to the zero code.
			res = vad_pkg::FP_ZERO;
		end else begin
			sh = ({15'h0000, val} << 14) >> q;
			res.m = sh[15:0];
			res.e = exp_base + 16'(q - 14);
		end
	end

endmodule

// >>> tb/encoder_model.sv
`timescale 1ns/1ps

// Stands in for the speech encoder that feeds one frame of analysis values at a time.
module encoder_model (
	input  wire logic          pclk,
	output logic               frame_stb,
	output vad_pkg::frame_in_s frame_in,
	output vad_pkg::rvad_t     avg_pred_autocorr,
	output logic               post_stb,
	output vad_pkg::lags_t     lags
);
	// Idle values are not valid data, so nothing is held quiet between strobes.
	initial begin
		frame_stb = 1'b0;
		post_stb = 1'b0;
		frame_in = '1;
		avg_pred_autocorr = '1;
		lags = '1;
	end

	// One strobe cycle; afterwards the values flip so stale data never looks valid.
	task automatic strobe(input logic fs, input logic ps, input logic [31:0] a0,
		input logic [3:0][15:0] k, input logic [31:0] dm, input vad_pkg::lags_t l);
		vad_pkg::frame_in_s f;
		f = '0;
		f.acf[0] = a0;
		f.reflection_coefs = k;
		f.dm = dm;
		@(posedge pclk);
		frame_stb <= fs;
		post_stb <= ps;
		frame_in <= f;
		avg_pred_autocorr <= {{8{16'h0000}}, 16'h0006};
		lags <= l;
		@(posedge pclk);
		frame_stb <= 1'b0;
		post_stb <= 1'b0;
		frame_in <= ~f;
		avg_pred_autocorr <= ~{{8{16'h0000}}, 16'h0006};
		lags <= ~l;
	endtask
endmodule

// >>> tb/voice_activity_decision_test.sv
`timescale 1ns/1ps

`define CHK(g, x) begin checked++; if ((g) !== (x)) begin n_errors++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (g), (x)); end end

module voice_activity_decision_test;
	// Frame energies that land on exact pseudo-float codes.
	localparam logic [31:0] LOUD = 32'h0003_A980;
	localparam logic [31:0] QUIET = 32'h0003_5B60;
	localparam logic [31:0] LOW = 32'h0003_0D40;
	localparam logic [63:0] TONE_K = 64'h7EB8_7EB8_7EB8_4000;
	localparam logic [63:0] NOISE_K = 64'h7EB8_7EB8_170A_A666;
	localparam vad_pkg::lags_t FORTY = {4{8'h28}};
	localparam vad_pkg::lags_t MIXED = {8'h31, 8'h2B, 8'h2F, 8'h2D};

	logic                pclk     = 1'b0;
	logic                presetn  = 1'b0;
	logic                psel     = 1'b0;
	logic                penable  = 1'b0;
	logic                pwrite   = 1'b0;
	logic [7:0]          paddr    = 8'h00;
	logic [31:0]         pwdata   = 32'h0000_0000;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                frame_stb;
	logic                post_stb;
	vad_pkg::frame_in_s  frame_in;
	vad_pkg::rvad_t      avg_pred_autocorr;
	vad_pkg::lags_t      lags;
	logic                vad_flag;
	logic                raw_vad;
	logic                tone_flag;
	logic                periodic_flag;
	logic                frame_done;
	logic [31:0]         d;
	logic                e;
	int                  n_errors = 0;
	int                  checked  = 0;
	int                  old_n;
	int                  vold_n;
	int                  lag0;

	// The 200 MHz clock.
	always #2.5 pclk = ~pclk;

	vad_decision i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frame_stb(frame_stb), .frame_in(frame_in),
		.avg_pred_autocorr(avg_pred_autocorr), .post_stb(post_stb), .lags(lags),
		.vad_flag(vad_flag), .raw_vad(raw_vad), .tone_flag(tone_flag),
		.periodic_flag(periodic_flag), .frame_done(frame_done));

	encoder_model i_enc (.pclk(pclk), .frame_stb(frame_stb), .frame_in(frame_in),
		.avg_pred_autocorr(avg_pred_autocorr), .post_stb(post_stb), .lags(lags));

	// Prints the counts and the verdict, then stops.
	task automatic results();
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// One APB transfer; read data and error are taken at the pready edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_errors++;
			results();
		end
	endtask

	// One strobe from the encoder, with the done pulse checked for exactly one cycle.
	task automatic step(input logic [31:0] a0, input logic [63:0] k, input logic [31:0] dm,
		input logic fs, input logic ps, input vad_pkg::lags_t l);
		i_enc.strobe(fs, ps, a0, k, dm, l);
		#1;
		`CHK(frame_done, fs)
		@(posedge pclk);
		#1;
		`CHK(frame_done, 1'b0)
	endtask

	function automatic int mn(input int a, input int b);
		return (a < b) ? a : b;
	endfunction

	// Bench model of the lag pair matching; the divisor minus residue is signed.
	function automatic int lag_hits(input vad_pkg::lags_t l, input int l0);
		int v[5];
		int n;
		int s;
		v[0] = l0;
		for (int i = 1; i < 5; i++) v[i] = l[i-1];
		n = 0;
		for (int j = 1; j < 5; j++) begin
			s = (v[j] > v[j-1]) ? v[j] : v[j-1];
			for (int i = 1; i < 4; i++) if (s >= mn(v[i], v[i-1])) s -= mn(v[i], v[i-1]);
			if (s < 2 || mn(v[j], v[j-1]) - s < 2) n++;
		end
		return n;
	endfunction

	// Post strobe, optionally with a frame, and the periodic flag it must give.
	task automatic lagstep(input logic fs, input vad_pkg::lags_t l);
		int c;
		step(QUIET, '0, '0, fs, 1'b1, l);
		c = lag_hits(l, lag0);
		lag0 = l[3];
		vold_n = old_n;
		old_n = c;
		`CHK(periodic_flag, 1'((old_n + vold_n) >= 7))
	endtask

	task automatic t_reset();
		apb(1'b0, vad_pkg::OFS_STATUS, '0);
		`CHK(d, 32'h0000_F008)
		`CHK(e, 1'b0)
		apb(1'b0, vad_pkg::OFS_THVAD, '0);
		`CHK(d, 32'h0015_5573)
		apb(1'b0, vad_pkg::OFS_PVAD, '0);
		`CHK(d, 32'h8000_0000)
		apb(1'b0, 8'h10, '0);
		`CHK({e, d}, {1'b1, 32'h0000_0000})
		$display("test reset done");
	endtask

	// Bursts of two and then three loud frames; only the second earns hangover.
	task automatic t_hang();
		logic [12:0] pat;
		logic        raw;
		int          burst;
		int          hang;
		pat = 13'h003B;
		burst = 0;
		hang = -1;
		for (int i = 0; i < 13; i++) begin
			raw = pat[i];
			step(raw ? LOUD : QUIET, '0, '0, 1'b1, 1'b0, '0);
			burst = raw ? burst + 1 : 0;
			if (burst >= 3) begin
				hang = 5;
				burst = 3;
			end
			`CHK(raw_vad, raw)
			`CHK(vad_flag, 1'(raw || hang >= 0))
			if (hang >= 0) hang--;
			apb(1'b0, vad_pkg::OFS_STATUS, '0);
			`CHK(d[15:8], {4'(hang), 2'b00, 2'(burst)})
		end
		`CHK(tone_flag, 1'b0)
		apb(1'b0, vad_pkg::OFS_THVAD, '0);
		`CHK(d, 32'h0015_5573)
		apb(1'b0, vad_pkg::OFS_PVAD, '0);
		`CHK(d, 32'h0015_5091)
		$display("test hangover done");
	endtask

	// Low energy loads the floor, then a soft reset restores every start value.
	task automatic t_low();
		step(LOW, '0, '0, 1'b1, 1'b0, '0);
		`CHK(raw_vad, 1'b1)
		apb(1'b0, vad_pkg::OFS_THVAD, '0);
		`CHK(d, 32'h0014_445C)
		apb(1'b1, vad_pkg::OFS_CTRL, 32'h0000_0001);
		apb(1'b0, vad_pkg::OFS_STATUS, '0);
		`CHK(d, 32'h0000_F008)
		apb(1'b0, vad_pkg::OFS_THVAD, '0);
		`CHK(d, 32'h0015_5573)
		apb(1'b0, vad_pkg::OFS_CTRL, '0);
		`CHK(d, 32'h0000_0000)
		$display("test low energy done");
	endtask

	// Periodicity rises, then a frame on the same edge still sees it set.
	task automatic t_period();
		lag0 = 21;
		old_n = 0;
		vold_n = 0;
		for (int i = 0; i < 3; i++) lagstep(1'b0, FORTY);
		lagstep(1'b1, MIXED);
		apb(1'b0, vad_pkg::OFS_THVAD, '0);
		`CHK(d, 32'h0015_5573)
		$display("test periodicity done");
	endtask

	// Adaptation when allowed, and none for a tone or an unsteady spectrum.
	task automatic t_adapt();
		logic [31:0] thv;
		step(QUIET, '0, '0, 1'b1, 1'b0, '0);
		apb(1'b0, vad_pkg::OFS_THVAD, '0);
		thv = d;
		`CHK(d[31:16] == 16'h0015 && d[15:0] >= 16'h57D0 && d[15:0] <= 16'h580C, 1'b1)
		apb(1'b0, vad_pkg::OFS_STATUS, '0);
		`CHK({d[23:16], d[4]}, {8'h01, 1'b1})
		step(QUIET, TONE_K, '0, 1'b1, 1'b0, '0);
		`CHK(tone_flag, 1'b1)
		apb(1'b0, vad_pkg::OFS_THVAD, '0);
		`CHK(d, thv)
		step(QUIET, '0, 32'h0000_4000, 1'b1, 1'b0, '0);
		apb(1'b0, vad_pkg::OFS_STATUS, '0);
		`CHK({d[23:16], d[4]}, {8'h01, 1'b0})
		step(QUIET, NOISE_K, 32'h0000_4000, 1'b1, 1'b0, '0);
		`CHK(tone_flag, 1'b0)
		// Steady frames lift the threshold until it sits on the steady target of
		// the quiet energy; a weaker frame then keeps the reduced value.
		repeat (40) step(QUIET, '0, 32'h0000_4000, 1'b1, 1'b0, '0);
		apb(1'b0, vad_pkg::OFS_THVAD, '0);
		`CHK(d, 32'h0016_66B6)
		step(32'h0003_3450, '0, 32'h0000_4000, 1'b1, 1'b0, '0);
		`CHK(raw_vad, 1'b0)
		apb(1'b0, vad_pkg::OFS_THVAD, '0);
		`CHK(d, 32'h0016_6380)
		$display("test adaptation done");
	endtask

	// Reset for ten cycles, then the scenarios in turn.
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_hang();
		t_low();
		t_period();
		t_adapt();
		results();
	end
endmodule
